// [pkg/block_ram_pkg.sv]
// Constants and types shared by the configurable block RAM.
// ==========================================================
// Overview of operation
// R1: 18-Kbit array, separately enabled input/output registers.
// R2: Single, true dual, pseudo dual port and ROM.
// R3: Single/pseudo dual ports: x1 to x36 organisations.
// R4: True dual port: x1 to x18, no x36.
// R5: Multi-port modes allow different widths per port.
// R6: Words fill the array LSB first, same map everywhere.
// R7: Optional parity bit stored beside each byte.
// R8: x18 and x36 writes honour byte enables.
// R9: Contents may be preloaded before user operation.
// R10: ROM use needs writes held off by user logic; here ROM mode drops all port writes itself.
// R11: Read data one clock after address; output register adds one.
package block_ram_pkg;
    // ==========================================================
    // Array geometry
    localparam int ROWS = 512;
    localparam int ROW_W = 36;
    localparam int ROW_AW = 9;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 14;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INIT_ADDR = 8'h08;
    localparam logic [7:0] OFS_INIT_LO = 8'h0C;
    localparam logic [7:0] OFS_INIT_HI = 8'h10;
    // ==========================================================
    // Configuration fields and reset values
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_WA_LSB = 4;
    localparam int CFG_WB_LSB = 8;
    localparam int CFG_OREG_A = 12;
    localparam int CFG_OREG_B = 13;
    localparam int CFG_LOAD = 16;
    localparam logic [31:0] CFG_MASK = 32'h0001_3773;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam int ST_CFG_ERR = 0;
    localparam int ST_LOADING = 1;
    // ==========================================================
    // Width codes
    localparam logic [2:0] WID_X1 = 3'h0;
    localparam logic [2:0] WID_X2 = 3'h1;
    localparam logic [2:0] WID_X4 = 3'h2;
    localparam logic [2:0] WID_X9 = 3'h3;
    localparam logic [2:0] WID_X18 = 3'h4;
    localparam logic [2:0] WID_X36 = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {MODE_SP, MODE_TDP, MODE_PDP, MODE_ROM} mode_e;
endpackage : block_ram_pkg

// [pkg/mem_core_if.sv]
// Interface between the port logic and the storage array.
`timescale 1ns/1ps
interface mem_core_if;
    logic we [2];
    logic [8:0] row [2];
    logic [35:0] wmask [2];
    logic [35:0] wdata [2];
    logic [35:0] rdata [2];
    logic init_we;
    logic [8:0] init_row;
    logic [35:0] init_data;
    modport core (input we, row, wmask, wdata, init_we, init_row, init_data, output rdata);
    modport user (output we, row, wmask, wdata, init_we, init_row, init_data, input rdata);
endinterface : mem_core_if

// [hw/mem_array.sv]
// Storage array with two masked write ports, asynchronous reads and a preload path.
`timescale 1ns/1ps
module mem_array #(
    parameter int ROWS = 512
) (
    input wire logic clock_i,
    mem_core_if.core bus
);
    import block_ram_pkg::*;
    // ==========================================================
    // Array
    if (ROWS != 512) begin : g_chk
        $error("mem_array supports only 512 rows of 36 bits");
    end
    logic [35:0] mem [ROWS];
    logic [35:0] new0;
    logic [35:0] base1;
    logic [35:0] new1;
    assign new0 = (mem[bus.row[0]] & ~bus.wmask[0]) | (bus.wdata[0] & bus.wmask[0]);
    // Port B builds on port A's result so a shared row keeps both updates.
    assign base1 = (bus.we[0] && bus.row[0] == bus.row[1]) ? new0 : mem[bus.row[1]];
    assign new1 = (base1 & ~bus.wmask[1]) | (bus.wdata[1] & bus.wmask[1]);
    always_ff @(posedge clock_i) begin
        if (bus.init_we) begin
            mem[bus.init_row] <= bus.init_data; // R9
        end
        if (bus.we[0]) begin
            mem[bus.row[0]] <= new0;
        end
        if (bus.we[1]) begin
            mem[bus.row[1]] <= new1;
        end
    end
    for (genvar p = 0; p < 2; p++) begin : g_rd
        assign bus.rdata[p] = mem[bus.row[p]];
    end
endmodule : mem_array

// [hw/block_ram.sv]
// Configurable block RAM with two user ports and an AXI4-Lite control slave.
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module block_ram #(
    parameter int ROWS = 512
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] axi_awaddr_i,
    input wire logic axi_awvalid_i,
    output logic axi_awready_o,
    input wire logic [31:0] axi_wdata_i,
    input wire logic [3:0] axi_wstrb_i,
    input wire logic axi_wvalid_i,
    output logic axi_wready_o,
    output logic [1:0] axi_bresp_o,
    output logic axi_bvalid_o,
    input wire logic axi_bready_i,
    input wire logic [7:0] axi_araddr_i,
    input wire logic axi_arvalid_i,
    output logic axi_arready_o,
    output logic [31:0] axi_rdata_o,
    output logic [1:0] axi_rresp_o,
    output logic axi_rvalid_o,
    input wire logic axi_rready_i,
    input wire logic [1:0] ce_i,
    input wire logic [1:0] oce_i,
    input wire logic [1:0] en_i,
    input wire logic [1:0] we_i,
    input wire logic [block_ram_pkg::ADDR_W-1:0] addr_a_i,
    input wire logic [block_ram_pkg::ADDR_W-1:0] addr_b_i,
    input wire logic [block_ram_pkg::ROW_W-1:0] wdata_a_i,
    input wire logic [block_ram_pkg::ROW_W-1:0] wdata_b_i,
    input wire logic [block_ram_pkg::LANES-1:0] be_a_i,
    input wire logic [block_ram_pkg::LANES-1:0] be_b_i,
    output logic [block_ram_pkg::ROW_W-1:0] rdata_a_o,
    output logic [block_ram_pkg::ROW_W-1:0] rdata_b_o
);
    import block_ram_pkg::*;

    // ==========================================================
    // Address mapping helpers
    function automatic logic [5:0] lsb_of(input logic [2:0] w, input logic [13:0] a);
        logic [4:0] d;
        d = 5'h00;
        case (w)
            WID_X1: d = a[4:0];
            WID_X2: d = {a[3:0], 1'b0};
            WID_X4: d = {a[2:0], 2'b00};
            default: d = 5'h00;
        endcase
        case (w)
            WID_X9: return 6'(a[1:0] * LANE_W);
            WID_X18: return 6'(a[0] * 2 * LANE_W);
            WID_X36: return 6'h00;
            // Narrow words skip the parity column of each lane.
            default: return 6'(d[4:3] * LANE_W + d[2:0]); // R6
        endcase
    endfunction : lsb_of

    function automatic logic [8:0] row_of(input logic [2:0] w, input logic [13:0] a);
        case (w)
            WID_X1: return a[13:5];
            WID_X2: return a[12:4];
            WID_X4: return a[11:3];
            WID_X9: return a[10:2];
            WID_X18: return a[9:1];
            default: return a[8:0];
        endcase
    endfunction : row_of

    function automatic logic [35:0] field_of(input logic [2:0] w, input logic [3:0] be);
        case (w)
            WID_X1: return 36'h0_0000_0001;
            WID_X2: return 36'h0_0000_0003;
            WID_X4: return 36'h0_0000_000F;
            WID_X9: return 36'h0_0000_01FF;
            WID_X18: return {18'h0_0000, {9{be[1]}}, {9{be[0]}}}; // R8
            default: return {{9{be[3]}}, {9{be[2]}}, {9{be[1]}}, {9{be[0]}}}; // R8
        endcase
    endfunction : field_of

    // ==========================================================
    // Configuration
    logic [31:0] cfg_q;
    logic [8:0] init_row_q;
    logic [31:0] init_lo_q;
    mode_e mode;
    logic [2:0] wid [2];
    logic [1:0] oreg;
    logic loading;
    logic cfg_err;
    assign mode = mode_e'(cfg_q[CFG_MODE_LSB +: 2]); // R2
    assign wid[0] = cfg_q[CFG_WA_LSB +: 3]; // R5
    assign wid[1] = cfg_q[CFG_WB_LSB +: 3]; // R5
    assign oreg = {cfg_q[CFG_OREG_B], cfg_q[CFG_OREG_A]};
    assign loading = cfg_q[CFG_LOAD];
    // Codes above x36 are illegal anywhere; x36 is illegal with both ports writing.
    assign cfg_err = (wid[0] > WID_X36) || (wid[1] > WID_X36) // R3
        || (mode == MODE_TDP && (wid[0] == WID_X36 || wid[1] == WID_X36)); // R4

    logic [1:0] port_on;
    logic [1:0] wr_ok;
    // Port B idles in single-port and ROM; pseudo dual port writes on A, reads on B.
    assign port_on = (loading || cfg_err) ? 2'b00 : (mode == MODE_TDP || mode == MODE_PDP)
        ? 2'b11 : 2'b01; // R2
    assign wr_ok[0] = (mode != MODE_ROM); // R10
    assign wr_ok[1] = (mode == MODE_TDP);

    // ==========================================================
    // User ports
    mem_core_if core_bus ();
    logic [13:0] addr_in [2];
    logic [35:0] wdata_in [2];
    logic [3:0] be_in [2];
    assign addr_in[0] = addr_a_i;
    assign addr_in[1] = addr_b_i;
    assign wdata_in[0] = wdata_a_i;
    assign wdata_in[1] = wdata_b_i;
    assign be_in[0] = be_a_i;
    assign be_in[1] = be_b_i;
    logic [35:0] rdata_q [2];
    assign rdata_a_o = rdata_q[0];
    assign rdata_b_o = rdata_q[1];

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic act_q;
        logic we_q;
        logic [13:0] addr_q;
        logic [35:0] wdata_q;
        logic [3:0] be_q;
        logic [35:0] stage_q;
        logic [5:0] lsb;
        logic [35:0] field;
        logic [35:0] rd_word;
        logic rd_act;
        assign lsb = lsb_of(wid[p], addr_q);
        assign field = field_of(wid[p], be_q);
        assign core_bus.row[p] = row_of(wid[p], addr_q); // R6
        assign core_bus.we[p] = act_q && we_q && port_on[p] && wr_ok[p];
        assign core_bus.wmask[p] = 36'(field << lsb); // R8
        // Parity columns are stored as written and returned on read.
        assign core_bus.wdata[p] = 36'(wdata_q << lsb); // R7
        assign rd_word = 36'(core_bus.rdata[p] >> lsb) & field_of(wid[p], 4'hF);
        // A refused write is dropped outright; it must not turn into a read.
        assign rd_act = act_q && port_on[p] && !we_q && !(p == 0 && mode == MODE_PDP);
        // Input register: captured only when its clock enable is high.
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                act_q <= 1'b0;
                we_q <= 1'b0;
                addr_q <= '0;
                wdata_q <= '0;
                be_q <= 4'h0;
            end else begin
                act_q <= ce_i[p] && en_i[p]; // R1
                if (ce_i[p] && en_i[p]) begin
                    we_q <= we_i[p];
                    addr_q <= addr_in[p];
                    wdata_q <= wdata_in[p];
                    be_q <= be_in[p];
                end
            end
        end
        // Output stage: direct after one clock, or one more clock through the output register.
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                stage_q <= '0;
                rdata_q[p] <= '0;
            end else begin
                if (rd_act) begin
                    stage_q <= rd_word; // R11
                end
                if (!oreg[p] && rd_act) begin
                    rdata_q[p] <= rd_word; // R11
                end else if (oreg[p] && oce_i[p]) begin
                    rdata_q[p] <= stage_q; // R1
                end
            end
        end
    end

    mem_array #(
        .ROWS(ROWS)
    ) u_array (
        .clock_i(clock_i),
        .bus(core_bus)
    );

    // ==========================================================
    // AXI4-Lite write channel
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] waddr_q;
    logic [31:0] wdat_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic reg_we;
    logic wmapped;
    assign reg_we = aw_hold_q && w_hold_q && !bvalid_q;
    assign wmapped = waddr_q == OFS_CONFIG || waddr_q == OFS_STATUS || waddr_q == OFS_INIT_ADDR
        || waddr_q == OFS_INIT_LO || waddr_q == OFS_INIT_HI;
    assign axi_awready_o = awready_q;
    assign axi_wready_o = wready_q;
    assign axi_bvalid_o = bvalid_q;
    assign axi_bresp_o = bresp_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= 8'h00;
            wdat_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (awready_q && axi_awvalid_i) begin
                aw_hold_q <= 1'b1;
                awready_q <= 1'b0;
                waddr_q <= {axi_awaddr_i[7:2], 2'b00};
            end
            if (wready_q && axi_wvalid_i) begin
                w_hold_q <= 1'b1;
                wready_q <= 1'b0;
                wdat_q <= axi_wdata_i;
                wstrb_q <= axi_wstrb_i;
            end
            if (reg_we) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wmapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && axi_bready_i) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Registers and preload path
    logic init_commit;
    assign init_commit = reg_we && waddr_q == OFS_INIT_HI && loading;
    assign core_bus.init_we = init_commit; // R9
    assign core_bus.init_row = init_row_q;
    assign core_bus.init_data = {wdat_q[3:0], init_lo_q};
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
            init_row_q <= 9'h000;
            init_lo_q <= 32'h0000_0000;
        end else if (reg_we) begin
            if (waddr_q == OFS_CONFIG) begin
                for (int i = 0; i < 4; i++) begin
                    if (wstrb_q[i]) begin
                        cfg_q[8*i +: 8] <= wdat_q[8*i +: 8] & CFG_MASK[8*i +: 8];
                    end
                end
            end
            if (waddr_q == OFS_INIT_ADDR) begin
                init_row_q <= wdat_q[8:0];
            end
            if (waddr_q == OFS_INIT_LO) begin
                init_lo_q <= wdat_q;
            end
            if (init_commit) begin
                init_row_q <= init_row_q + 9'h001;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdat_q;
    logic [1:0] rresp_q;
    logic [7:0] raddr;
    logic [31:0] rsel;
    logic rmapped;
    assign raddr = {axi_araddr_i[7:2], 2'b00};
    assign rmapped = raddr == OFS_CONFIG || raddr == OFS_STATUS || raddr == OFS_INIT_ADDR
        || raddr == OFS_INIT_LO || raddr == OFS_INIT_HI;
    assign rsel = (raddr == OFS_CONFIG) ? cfg_q
        : (raddr == OFS_STATUS) ? {30'h0000_0000, loading, cfg_err}
        : (raddr == OFS_INIT_ADDR) ? {23'h00_0000, init_row_q}
        : (raddr == OFS_INIT_LO) ? init_lo_q : 32'h0000_0000;
    assign axi_arready_o = arready_q;
    assign axi_rvalid_o = rvalid_q;
    assign axi_rdata_o = rdat_q;
    assign axi_rresp_o = rresp_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arready_q && axi_arvalid_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdat_q <= rsel;
            rresp_q <= rmapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end
endmodule : block_ram

// [verification/block_ram_asserts.sv]
// Port-level assertions for the block RAM.
`timescale 1ns/1ps
module block_ram_asserts (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic axi_awvalid_i,
    input wire logic axi_awready_o,
    input wire logic axi_wvalid_i,
    input wire logic axi_wready_o,
    input wire logic [1:0] axi_bresp_o,
    input wire logic axi_bvalid_o,
    input wire logic axi_bready_i,
    input wire logic axi_arvalid_i,
    input wire logic axi_arready_o,
    input wire logic [31:0] axi_rdata_o,
    input wire logic [1:0] axi_rresp_o,
    input wire logic axi_rvalid_o,
    input wire logic axi_rready_i,
    input wire logic [1:0] ce_i,
    input wire logic [1:0] oce_i,
    input wire logic [1:0] en_i,
    input wire logic [1:0] we_i,
    input wire logic [block_ram_pkg::ROW_W-1:0] rdata_a_o,
    input wire logic [block_ram_pkg::ROW_W-1:0] rdata_b_o
);
    import block_ram_pkg::*;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Control bus
    property p_b_due;
        axi_awvalid_i && axi_awready_o && axi_wvalid_i && axi_wready_o |-> ##2 axi_bvalid_o;
    endproperty
    a_b_due: assert property (p_b_due) else $error("no write response");
    property p_b_hold;
        axi_bvalid_o && !axi_bready_i |=> axi_bvalid_o && $stable(axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_b_block;
        axi_bvalid_o |-> !axi_awready_o && !axi_wready_o;
    endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while busy");
    property p_b_free;
        axi_bvalid_o && axi_bready_i |=> !axi_bvalid_o && axi_awready_o && axi_wready_o;
    endproperty
    a_b_free: assert property (p_b_free) else $error("write side not freed");
    property p_r_due;
        axi_arvalid_i && axi_arready_o |=> axi_rvalid_o && !axi_arready_o;
    endproperty
    a_r_due: assert property (p_r_due) else $error("no read response");
    property p_r_hold;
        axi_rvalid_o && !axi_rready_i |=> axi_rvalid_o ##0 $stable({axi_rdata_o, axi_rresp_o});
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    // ==========================================================
    // Memory ports: only a read capture or an output-register enable moves read data.
    property p_a_quiet;
        !(ce_i[0] && en_i[0] && !we_i[0]) ##1 !oce_i[0] |=> $stable(rdata_a_o);
    endproperty
    a_a_quiet: assert property (p_a_quiet) else $error("port A data moved");
    property p_b_quiet;
        !(ce_i[1] && en_i[1] && !we_i[1]) ##1 !oce_i[1] |=> $stable(rdata_b_o);
    endproperty
    a_b_quiet: assert property (p_b_quiet) else $error("port B data moved");
endmodule : block_ram_asserts
bind block_ram block_ram_asserts chk_u (.clock_i, .rst_n_i, .axi_awvalid_i, .axi_awready_o,
    .axi_wvalid_i, .axi_wready_o, .axi_bresp_o, .axi_bvalid_o, .axi_bready_i, .axi_arvalid_i,
    .axi_arready_o, .axi_rdata_o, .axi_rresp_o, .axi_rvalid_o, .axi_rready_i, .ce_i, .oce_i,
    .en_i, .we_i, .rdata_a_o, .rdata_b_o);

// [verification/fabric_port.sv]
// User fabric model that drives one memory port.
`timescale 1ns/1ps
module fabric_port (
    input wire logic clock_i,
    input wire logic [block_ram_pkg::ROW_W-1:0] rdata_i,
    output logic ce_o,
    output logic oce_o,
    output logic en_o,
    output logic we_o,
    output logic [block_ram_pkg::ADDR_W-1:0] addr_o,
    output logic [block_ram_pkg::ROW_W-1:0] wdata_o,
    output logic [block_ram_pkg::LANES-1:0] be_o
);
    import block_ram_pkg::*;
    // The output register enable stays low except for one pulse per access.
    initial begin
        ce_o = 1'b0;
        oce_o = 1'b0;
        en_o = 1'b0;
        we_o = 1'b0;
        addr_o = '0;
        wdata_o = '0;
        be_o = '0;
    end
    // ==========================================================
    // One access; idle lines flip so stale values cannot pass as data.
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [ROW_W-1:0] d,
        input logic [LANES-1:0] b, output logic [ROW_W-1:0] rd);
        @(posedge clock_i);
        ce_o <= 1'b1;
        en_o <= 1'b1;
        we_o <= w;
        addr_o <= a;
        wdata_o <= d;
        be_o <= b;
        @(posedge clock_i);
        ce_o <= 1'b0;
        en_o <= 1'b0;
        we_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        be_o <= ~b;
        // A bypassed port already shows the word; a registered one takes it on this pulse.
        @(posedge clock_i);
        oce_o <= 1'b1;
        @(posedge clock_i);
        oce_o <= 1'b0;
        #1 rd = rdata_i;
    endtask : acc
endmodule : fabric_port

// [verification/tb_top.sv]
// Self-checking bench for the configurable block RAM.
`timescale 1ns/1ps
module tb_top;
    import block_ram_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp, ce, oce, en, we;
    wire [31:0] rdata;
    wire [ADDR_W-1:0] addr_a, addr_b;
    wire [ROW_W-1:0] wd_a, wd_b, rd_a, rd_b;
    wire [LANES-1:0] be_a, be_b;
    logic [ROW_W-1:0] mm [ROWS];
    logic [15:0] seed = 16'h003F;
    int lim [5] = '{128, 64, 32, 16, 8};
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    fabric_port pa (.clock_i(clk), .rdata_i(rd_a), .ce_o(ce[0]), .oce_o(oce[0]), .en_o(en[0]),
        .we_o(we[0]), .addr_o(addr_a), .wdata_o(wd_a), .be_o(be_a));
    fabric_port pb (.clock_i(clk), .rdata_i(rd_b), .ce_o(ce[1]), .oce_o(oce[1]), .en_o(en[1]),
        .we_o(we[1]), .addr_o(addr_b), .wdata_o(wd_b), .be_o(be_b));
    block_ram dut_u (.clock_i(clk), .rst_n_i(rst_n), .axi_awaddr_i(awaddr),
        .axi_awvalid_i(awvalid), .axi_awready_o(awready), .axi_wdata_i(wdata),
        .axi_wstrb_i(4'hF), .axi_wvalid_i(wvalid), .axi_wready_o(wready), .axi_bresp_o(bresp),
        .axi_bvalid_o(bvalid), .axi_bready_i(bready), .axi_araddr_i(araddr),
        .axi_arvalid_i(arvalid), .axi_arready_o(arready), .axi_rdata_o(rdata),
        .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready), .ce_i(ce),
        .oce_i(oce), .en_i(en), .we_i(we), .addr_a_i(addr_a), .addr_b_i(addr_b),
        .wdata_a_i(wd_a), .wdata_b_i(wd_b), .be_a_i(be_a), .be_b_i(be_b), .rdata_a_o(rd_a),
        .rdata_b_o(rd_b));
    always #25 clk = ~clk;
    // Roughly ten times the cycles the sequence needs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            give_verdict();
        end
    end
    // ==========================================================
    // Helpers
    task automatic give_verdict();
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [ROW_W-1:0] got, input logic [ROW_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [ROW_W-1:0] rnd36();
        logic [ROW_W-1:0] r;
        r = '0;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            r = {r[19:0], seed};
        end
        return r;
    endfunction : rnd36
    function automatic logic [31:0] cfg(input mode_e m, input logic [2:0] a, input logic [2:0] b);
        return (32'(m) << CFG_MODE_LSB) | (32'(a) << CFG_WA_LSB) | (32'(b) << CFG_WB_LSB);
    endfunction : cfg
    // Narrow words use only the eight data bits of each lane, lane by lane.
    function automatic logic [ROW_W-1:0] word_of(input logic [2:0] w, input int a);
        logic [ROW_W-1:0] r;
        int n;
        int b;
        r = '0;
        n = 1 << w;
        case (w)
            WID_X9: r[8:0] = mm[a >> 2][9 * (a % 4) +: 9];
            WID_X18: r[17:0] = mm[a >> 1][18 * (a % 2) +: 18];
            WID_X36: r = mm[a];
            default: for (int i = 0; i < n; i++) begin
                b = a * n + i;
                r[i] = mm[b >> 5][9 * ((b % 32) >> 3) + b % 8];
            end
        endcase
        return r;
    endfunction : word_of
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw;
        bit dw;
        aw = 1'b0;
        dw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && dw)) begin
            @(posedge clk);
            aw = aw | awready;
            dw = dw | wready;
            awvalid <= !aw;
            wvalid <= !dw;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
        chk(36'(bresp), 36'(er));
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        chk(36'(rdata), 36'(ed));
        chk(36'(rresp), 36'(er));
    endtask : axi_rd
    task automatic port(input bit p, input logic w, input int a, input logic [ROW_W-1:0] d,
        input logic [LANES-1:0] b, output logic [ROW_W-1:0] rd);
        if (p) pb.acc(w, 14'(a), d, b, rd);
        else pa.acc(w, 14'(a), d, b, rd);
    endtask : port
    task automatic wr36(input bit p, input int r, input logic [LANES-1:0] b, input bit ok);
        logic [ROW_W-1:0] d;
        logic [ROW_W-1:0] q;
        d = rnd36();
        port(p, 1'b1, r, d, b, q);
        for (int l = 0; l < LANES; l++) if (ok && b[l]) mm[r][9 * l +: 9] = d[9 * l +: 9];
    endtask : wr36
    task automatic rd_chk(input bit p, input logic [2:0] w, input int a);
        logic [ROW_W-1:0] q;
        port(p, 1'b0, a, '0, '0, q);
        chk(q, word_of(w, a));
    endtask : rd_chk
    // ==========================================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_wr(OFS_CONFIG, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(OFS_CONFIG, CFG_MASK, RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0000_0003, RESP_OKAY);
        axi_wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_rd(8'h14, 32'h0000_0000, RESP_SLVERR);
        axi_wr(OFS_CONFIG, 32'h1 << CFG_LOAD, RESP_OKAY);
        axi_wr(OFS_INIT_ADDR, 32'h0000_0000, RESP_OKAY);
        for (int r = 0; r < 4; r++) begin
            mm[r] = rnd36();
            axi_wr(OFS_INIT_LO, mm[r][31:0], RESP_OKAY);
            axi_wr(OFS_INIT_HI, 32'(mm[r][35:32]), RESP_OKAY);
        end
        wr36(1'b0, 0, 4'hF, 1'b0);
        axi_wr(OFS_CONFIG, cfg(MODE_PDP, WID_X36, WID_X9), RESP_OKAY);
        wr36(1'b0, 1, 4'h5, 1'b1);
        wr36(1'b0, 2, 4'hA, 1'b1);
        wr36(1'b1, 0, 4'hF, 1'b0);
        for (int a = 0; a < 16; a++) rd_chk(1'b1, WID_X9, a);
        for (int w = 0; w < 5; w++) begin
            axi_wr(OFS_CONFIG, cfg(MODE_SP, 3'(w), WID_X1), RESP_OKAY);
            for (int i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                rd_chk(1'b0, 3'(w), int'(seed) % lim[w]);
            end
        end
        axi_wr(OFS_CONFIG, cfg(MODE_TDP, WID_X36, WID_X1), RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
        axi_wr(OFS_CONFIG, cfg(MODE_TDP, WID_X18, WID_X2), RESP_OKAY);
        axi_rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
        rd_chk(1'b1, WID_X2, 21);
        axi_wr(OFS_CONFIG, cfg(MODE_ROM, WID_X36, WID_X36) | 32'h1 << CFG_OREG_A,
            RESP_OKAY);
        wr36(1'b0, 3, 4'hF, 1'b0);
        rd_chk(1'b0, WID_X36, 3);
        give_verdict();
    end
endmodule : tb_top
